// >>> src/pcr_pkg.sv
// Constants, types and helpers shared by the hub port configuration block.
// Assumes one 200 MHz clock domain; registers are 8 bits wide.
package pcr_pkg;

    localparam int PCR_NUM_PORTS = 7;

    typedef logic [7:1]      pcr_ports_type;
    typedef logic [2:0]      pcr_pnum_type;
    typedef logic [7:1][2:0] pcr_pnums_type;

    // Register offsets on the configuration port
    localparam logic [7:0] PCR_OFS_CFG3  = 8'h08;
    localparam logic [7:0] PCR_OFS_FIXED = 8'h09;
    localparam logic [7:0] PCR_OFS_SPOFF = 8'h0A;

    // Values after reset
    localparam logic [7:0] PCR_CFG3_RST  = 8'h00;
    localparam logic [7:0] PCR_FIXED_RST = 8'h00;
    localparam logic [7:0] PCR_SPOFF_RST = 8'h00;

    // Writable bits; the rest read as zero
    localparam logic [7:0] PCR_CFG3_WMASK = 8'h0F;
    localparam logic [7:0] PCR_PORT_WMASK = 8'hFE;

    // Field positions in config_byte_three
    localparam int PCR_REMAP_BIT  = 3;
    localparam int PCR_LED_LSB    = 1;
    localparam int PCR_STRING_BIT = 0;

    // Indicator mode codes
    localparam logic [1:0] PCR_LED_SPEED = 2'h1;

    // Fixed device masks chosen by the two straps
    localparam logic [7:0] PCR_STRAP_NR0 = 8'h00;
    localparam logic [7:0] PCR_STRAP_NR1 = 8'h02;
    localparam logic [7:0] PCR_STRAP_NR2 = 8'h06;
    localparam logic [7:0] PCR_STRAP_NR3 = 8'h0E;

    function automatic pcr_pnum_type pcr_count_ones(input pcr_ports_type v);
        pcr_pnum_type c;
        c = 3'h0;
        for (int i = 1; i <= PCR_NUM_PORTS; i++) begin
            c = c + {2'h0, v[i]};
        end
        return c;
    endfunction : pcr_count_ones

    function automatic logic [7:0] pcr_strap_mask(input logic [1:0] s);
        unique case (s)
            2'h0: return PCR_STRAP_NR0;
            2'h1: return PCR_STRAP_NR1;
            2'h2: return PCR_STRAP_NR2;
            2'h3: return PCR_STRAP_NR3;
        endcase
    endfunction : pcr_strap_mask

endpackage : pcr_pkg

// >>> src/pcr_port_if.sv
// Port state shared between the configuration top and its helpers.
// Assumes all members belong to the single block clock.
`timescale 1ns/1ps
interface pcr_port_if;
    import pcr_pkg::*;
    pcr_ports_type active;     // Ports visible to the host
    logic          speed_mode; // Indicators show link speed
    pcr_pnum_type  port_count; // Count of visible ports
    pcr_pnums_type log_num;    // Host number per physical port, 0 if hidden

    modport ctrl  (output active, output speed_mode, input port_count, input log_num);
    modport remap (input active, output port_count, output log_num);
    modport led   (input active, input speed_mode);
endinterface : pcr_port_if

// >>> src/pcr_remap.sv
// Packs visible ports into consecutive host numbers from 1 upward.
// Assumes the active mask is stable logic of the block clock.
`timescale 1ns/1ps
module pcr_remap
    import pcr_pkg::*;
(
    pcr_port_if.remap pif // Port state
);
    pcr_pnum_type run_c;

    always_comb begin
        run_c = 3'h0;
        pif.log_num = '0;
        for (int p = 1; p <= PCR_NUM_PORTS; p++) begin
            if (pif.active[p]) begin
                run_c = run_c + 3'h1;
                pif.log_num[p] = run_c;
            end
        end
    end

    assign pif.port_count = pcr_count_ones(pif.active);
endmodule : pcr_remap

// >>> src/pcr_led.sv
// Per-port indicator drivers, active low, registered.
// Assumes status inputs come from hub logic on the same clock.
`timescale 1ns/1ps
module pcr_led
    import pcr_pkg::*;
(
    input  wire logic    clk_in,    // Block clock
    input  wire logic    rst_n_in,  // Async reset, active low
    pcr_port_if.led      pif,       // Port state
    input  pcr_ports_type green_in, // USB mode green request
    input  pcr_ports_type amber_in, // USB mode amber request
    input  pcr_ports_type hs_in,    // High speed link per port
    input  pcr_ports_type fs_in,    // Full speed link per port
    output pcr_ports_type a_n_out,  // Indicator A, low lit
    output pcr_ports_type b_n_out   // Indicator B, low lit
);
    pcr_ports_type a_n_q;
    pcr_ports_type b_n_q;

    // Hidden ports stay dark so a disabled socket never looks alive
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            a_n_q <= 7'h7F;
            b_n_q <= 7'h7F;
        end else if (pif.speed_mode) begin
            a_n_q <= ~(hs_in & pif.active);
            b_n_q <= ~(fs_in & pif.active);
        end else begin
            a_n_q <= ~(green_in & pif.active);
            b_n_q <= ~(amber_in & pif.active);
        end
    end

    assign a_n_out = a_n_q;
    assign b_n_out = b_n_q;

    property p_led_usb;
        @(posedge clk_in) disable iff (!rst_n_in)
        !pif.speed_mode |=> a_n_out == ~($past(green_in) & $past(pif.active));
    endproperty
    a_led_usb: assert property (p_led_usb) else $error("usb mode indicator mismatch");

    property p_led_speed;
        @(posedge clk_in) disable iff (!rst_n_in)
        pif.speed_mode |=> b_n_out == ~($past(fs_in) & $past(pif.active));
    endproperty
    a_led_speed: assert property (p_led_speed) else $error("speed mode indicator mismatch");
endmodule : pcr_led

// >>> src/pcr_hub_port_cfg.sv
// Port configuration registers of a seven-port hub and the derived port view.
// Assumes a loader (EEPROM or SMBus engine) on the same clock drives the
// config port; strap and power pins are asynchronous and get synchronised.
`timescale 1ns/1ps
module pcr_hub_port_cfg
    import pcr_pkg::*;
(
    input  wire logic    CLK_IN,                 // 200 MHz block clock
    input  wire logic    RST_N_IN,               // Async reset, active low
    input  wire logic    CFG_WE_IN,              // Register write strobe
    input  wire logic [7:0] CFG_ADDR_IN,         // Write offset
    input  wire logic [7:0] CFG_WDATA_IN,        // Write data
    input  wire logic [7:0] CFG_RADDR_IN,        // Read offset
    output logic [7:0]   CFG_RDATA_OUT,          // Read data, one cycle later
    input  wire logic    STRAP_MODE_IN,          // Pin: use strap defaults
    input  wire logic [1:0] FIXED_DEVICE_STRAPS_IN, // Pins: fixed port straps
    input  wire logic    SELF_POWERED_IN,        // Pin: local power present
    input  wire logic    COMPOUND_CFG_IN,        // Compound flag from config
    input  pcr_ports_type LED_GREEN_IN,          // USB mode green request
    input  pcr_ports_type LED_AMBER_IN,          // USB mode amber request
    input  pcr_ports_type SPEED_HS_IN,           // High speed link per port
    input  pcr_ports_type SPEED_FS_IN,           // Full speed link per port
    output pcr_ports_type PORT_INDICATOR_A_N_OUT, // Indicator A, low lit
    output pcr_ports_type PORT_INDICATOR_B_N_OUT, // Indicator B, low lit
    output pcr_ports_type PORT_ACTIVE_OUT,       // Physical ports seen by host
    output pcr_pnum_type  PORT_COUNT_OUT,        // Reported port count
    output logic [20:0]   PORT_NUMBERS_OUT,      // Host number per port, 3 bits
    output logic [7:0]    FIXED_REPORT_OUT,      // Non-removable map, host order
    output logic          COMPOUND_OUT,          // Hub reports compound device
    output logic          LED_SUPPORT_OUT,       // Hub advertises indicators
    output logic          STRING_EN_OUT,         // String descriptors served
    output logic          REMAP_MODE_OUT         // Port re-map mode selected
);
    logic [7:0]    cfg3_q;
    logic [7:0]    fixed_q;
    logic [7:0]    spoff_q;
    logic [7:0]    rdata_q;
    logic          strap_s1_q;
    logic          strap_s2_q;
    logic [1:0]    straps_s1_q;
    logic [1:0]    straps_s2_q;
    logic          selfp_s1_q;
    logic          selfp_s2_q;
    logic [7:0]    fixed_eff;
    logic          remap_sel;
    logic [1:0]    led_field;
    logic          speed_sel;
    pcr_ports_type active_d;
    logic [7:0]    report_d;
    pcr_ports_type active_q;
    pcr_pnum_type  count_q;
    logic [20:0]   numbers_q;
    logic [7:0]    report_q;
    logic          compound_q;
    logic          led_sup_q;
    logic          string_q;
    logic          remap_q;

    pcr_port_if pif ();

    // Configuration writes; reserved bits are never stored
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cfg3_q  <= PCR_CFG3_RST;
            fixed_q <= PCR_FIXED_RST;
            spoff_q <= PCR_SPOFF_RST;
        end else if (CFG_WE_IN) begin
            if (CFG_ADDR_IN == PCR_OFS_CFG3) begin
                cfg3_q <= CFG_WDATA_IN & PCR_CFG3_WMASK;
            end
            if (CFG_ADDR_IN == PCR_OFS_FIXED) begin
                fixed_q <= CFG_WDATA_IN & PCR_PORT_WMASK;
            end
            if (CFG_ADDR_IN == PCR_OFS_SPOFF) begin
                spoff_q <= CFG_WDATA_IN & PCR_PORT_WMASK;
            end
        end
    end

    // Read back; unmapped offsets answer zero
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rdata_q <= 8'h00;
        end else begin
            unique case (CFG_RADDR_IN)
                PCR_OFS_CFG3:  rdata_q <= cfg3_q;
                PCR_OFS_FIXED: rdata_q <= fixed_q;
                PCR_OFS_SPOFF: rdata_q <= spoff_q;
                default:       rdata_q <= 8'h00;
            endcase
        end
    end

    // Pin synchronisers
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            strap_s1_q  <= 1'b0;
            strap_s2_q  <= 1'b0;
            straps_s1_q <= 2'h0;
            straps_s2_q <= 2'h0;
            selfp_s1_q  <= 1'b0;
            selfp_s2_q  <= 1'b0;
        end else begin
            strap_s1_q  <= STRAP_MODE_IN;
            strap_s2_q  <= strap_s1_q;
            straps_s1_q <= FIXED_DEVICE_STRAPS_IN;
            straps_s2_q <= straps_s1_q;
            selfp_s1_q  <= SELF_POWERED_IN;
            selfp_s2_q  <= selfp_s1_q;
        end
    end

    // Straps replace the register so a hub without EEPROM still reports fixed ports
    assign fixed_eff = strap_s2_q ? pcr_strap_mask(straps_s2_q) : fixed_q;
    assign remap_sel = cfg3_q[PCR_REMAP_BIT];
    assign led_field = cfg3_q[PCR_LED_LSB +: 2];
    assign speed_sel = (led_field == PCR_LED_SPEED);

    // Re-map mode uses its own method, so the disable mask is not applied there.
    // Bus-powered disable lives outside this block; all ports stay visible then.
    assign active_d = (selfp_s2_q && !remap_sel) ? ~spoff_q[7:1] : 7'h7F;

    assign pif.active     = active_d;
    assign pif.speed_mode = speed_sel;

    // Fixed device map in host numbering, only for visible ports
    always_comb begin
        report_d = 8'h00;
        for (int p = 1; p <= PCR_NUM_PORTS; p++) begin
            if (active_d[p] && fixed_eff[p]) begin
                report_d[pif.log_num[p]] = 1'b1;
            end
        end
    end

    pcr_remap u_remap (
        .pif (pif.remap)
    );

    pcr_led u_led (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .pif      (pif.led),
        .green_in (LED_GREEN_IN),
        .amber_in (LED_AMBER_IN),
        .hs_in    (SPEED_HS_IN),
        .fs_in    (SPEED_FS_IN),
        .a_n_out  (PORT_INDICATOR_A_N_OUT),
        .b_n_out  (PORT_INDICATOR_B_N_OUT)
    );

    // Descriptor-facing outputs, registered one cycle after the settings change
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            active_q   <= 7'h00;
            count_q    <= 3'h0;
            numbers_q  <= 21'h00000;
            report_q   <= 8'h00;
            compound_q <= 1'b0;
            led_sup_q  <= 1'b0;
            string_q   <= 1'b0;
            remap_q    <= 1'b0;
        end else begin
            active_q   <= active_d;
            count_q    <= pif.port_count;
            numbers_q  <= pif.log_num;
            report_q   <= report_d;
            compound_q <= strap_s2_q ? (|fixed_eff) : COMPOUND_CFG_IN;
            led_sup_q  <= !speed_sel;
            string_q   <= cfg3_q[PCR_STRING_BIT];
            remap_q    <= remap_sel;
        end
    end

    assign CFG_RDATA_OUT    = rdata_q;
    assign PORT_ACTIVE_OUT  = active_q;
    assign PORT_COUNT_OUT   = count_q;
    assign PORT_NUMBERS_OUT = numbers_q;
    assign FIXED_REPORT_OUT = report_q;
    assign COMPOUND_OUT     = compound_q;
    assign LED_SUPPORT_OUT  = led_sup_q;
    assign STRING_EN_OUT    = string_q;
    assign REMAP_MODE_OUT   = remap_q;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence s_cfg3_write;
        CFG_WE_IN && CFG_ADDR_IN == PCR_OFS_CFG3;
    endsequence

    property p_remap_follow;
        s_cfg3_write ##1 !CFG_WE_IN |-> ##1 REMAP_MODE_OUT == $past(CFG_WDATA_IN[3], 2);
    endproperty
    a_remap_follow: assert property (p_remap_follow) else $error("remap mode not taken");

    property p_led_support;
        s_cfg3_write ##1 !CFG_WE_IN |->
            ##1 LED_SUPPORT_OUT == ($past(CFG_WDATA_IN[2:1], 2) != 2'h1);
    endproperty
    a_led_support: assert property (p_led_support) else $error("led support wrong");

    property p_string_follow;
        s_cfg3_write ##1 !CFG_WE_IN |-> ##1 STRING_EN_OUT == $past(CFG_WDATA_IN[0], 2);
    endproperty
    a_string_follow: assert property (p_string_follow) else $error("string enable wrong");

    property p_cfg3_reserved;
        $past(CFG_RADDR_IN) == PCR_OFS_CFG3 |-> CFG_RDATA_OUT[7:4] == 4'h0;
    endproperty
    a_cfg3_reserved: assert property (p_cfg3_reserved) else $error("reserved bits set");

    property p_fixed_bit0;
        $past(CFG_RADDR_IN) == PCR_OFS_FIXED |-> CFG_RDATA_OUT[0] == 1'b0;
    endproperty
    a_fixed_bit0: assert property (p_fixed_bit0) else $error("fixed bit 0 set");

    property p_spoff_readback;
        CFG_WE_IN && CFG_ADDR_IN == PCR_OFS_SPOFF ##1
            (!CFG_WE_IN && CFG_RADDR_IN == PCR_OFS_SPOFF)
        |=> CFG_RDATA_OUT == ($past(CFG_WDATA_IN, 2) & 8'hFE);
    endproperty
    a_spoff_readback: assert property (p_spoff_readback) else $error("disable readback");

    property p_port_hidden;
        selfp_s2_q && !remap_sel |=> PORT_ACTIVE_OUT == ~$past(spoff_q[7:1]);
    endproperty
    a_port_hidden: assert property (p_port_hidden) else $error("disabled port visible");

    property p_count_match;
        PORT_COUNT_OUT == pcr_count_ones(PORT_ACTIVE_OUT);
    endproperty
    a_count_match: assert property (p_count_match) else $error("port count wrong");

    property p_strap_fixed;
        strap_s2_q |-> fixed_eff == {4'h0, straps_s2_q == 2'h3, straps_s2_q[1],
                                     straps_s2_q != 2'h0, 1'b0};
    endproperty
    a_strap_fixed: assert property (p_strap_fixed) else $error("straps ignored");

    property p_strap_compound;
        strap_s2_q && (|fixed_eff) |=> COMPOUND_OUT;
    endproperty
    a_strap_compound: assert property (p_strap_compound) else $error("compound missing");

    property p_report_fixed;
        !strap_s2_q && active_d[1] && fixed_q[1] |=> FIXED_REPORT_OUT[1];
    endproperty
    a_report_fixed: assert property (p_report_fixed) else $error("fixed port unreported");

    property p_spoff_bit0;
        $past(CFG_RADDR_IN) == PCR_OFS_SPOFF |-> CFG_RDATA_OUT[0] == 1'b0;
    endproperty
    a_spoff_bit0: assert property (p_spoff_bit0) else $error("disable bit 0 set");

    property p_fixed_readback;
        CFG_WE_IN && CFG_ADDR_IN == PCR_OFS_FIXED ##1
            (!CFG_WE_IN && CFG_RADDR_IN == PCR_OFS_FIXED)
        |=> CFG_RDATA_OUT == ($past(CFG_WDATA_IN, 2) & 8'hFE);
    endproperty
    a_fixed_readback: assert property (p_fixed_readback) else $error("fixed readback");

    // Indicators and active mask load on the same edge, so a hidden port is dark at once
    property p_hidden_dark;
        &(PORT_INDICATOR_A_N_OUT | PORT_ACTIVE_OUT) &&
            &(PORT_INDICATOR_B_N_OUT | PORT_ACTIVE_OUT);
    endproperty
    a_hidden_dark: assert property (p_hidden_dark) else $error("hidden port lit");

    property p_remap_all;
        remap_sel |=> PORT_ACTIVE_OUT == 7'h7F;
    endproperty
    a_remap_all: assert property (p_remap_all) else $error("remap mode hid ports");

    property p_first_number;
        PORT_NUMBERS_OUT[2:0] == {2'h0, PORT_ACTIVE_OUT[1]};
    endproperty
    a_first_number: assert property (p_first_number) else $error("port 1 number wrong");

    property p_last_number;
        PORT_ACTIVE_OUT[7] |-> PORT_NUMBERS_OUT[20:18] == PORT_COUNT_OUT;
    endproperty
    a_last_number: assert property (p_last_number) else $error("port 7 number wrong");

    c_remap_on:   cover property (s_cfg3_write ##2 REMAP_MODE_OUT);
    c_speed_mode: cover property (speed_sel ##1 !LED_SUPPORT_OUT);
    c_compound:   cover property (strap_s2_q ##1 COMPOUND_OUT);
    c_gap_ports:  cover property (PORT_COUNT_OUT == 3'h5 && !PORT_ACTIVE_OUT[3]);
endmodule : pcr_hub_port_cfg

// >>> tb/pcr_loader.sv
// Behavioural configuration loader standing where the EEPROM/SMBus engine sits.
// Assumes the same clock as the block; writes single bytes on request.
`timescale 1ns/1ps
module pcr_loader (
    input  wire logic       clk_in,   // Block clock
    output logic            we_out,   // Write strobe
    output logic [7:0]      addr_out, // Write offset
    output logic [7:0]      data_out  // Write data
);
    initial begin
        we_out   = 1'b0;
        addr_out = 8'h00;
        data_out = 8'h00;
    end

    // Gap adds idle edges; gap 0 still leaves one idle cycle between strobes; mode choice is the caller's duty
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        we_out   <= 1'b1;
        addr_out <= a;
        data_out <= d;
        @(posedge clk_in);
        we_out   <= 1'b0;
        // Released bus shows inverted values, never a stale copy
        addr_out <= ~a;
        data_out <= ~d;
    endtask : write_byte
endmodule : pcr_loader

// >>> tb/pcr_hub_port_cfg_test.sv
// Self-checking bench for the hub port configuration block.
// Assumes the loader model drives the write port; pins come from the bench.
`timescale 1ns/1ps
module pcr_hub_port_cfg_test;
    import pcr_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, we, strap_q = 1'b0, sp_q = 1'b0, comp_q = 1'b0;
    logic [7:0] waddr, wdata, raddr = 8'h00, rdata, report;
    logic [1:0] straps_q = 2'h0;
    pcr_ports_type grn = '0, amb = '0, hs = '0, fs = '0, a_n, b_n, active;
    pcr_pnum_type count;
    logic [20:0] nums;
    logic compound, led_sup, str_en, remap;
    int num_errors = 0, num_checks = 0, seed = 32'h8B8B;
    int m_cfg3 = 0, m_fixed = 0, m_spoff = 0;
    int smap[4] = '{8'h00, 8'h02, 8'h06, 8'h0E};

    initial forever #2.5 clk = ~clk;

    pcr_loader u_pcr_loader (.clk_in(clk), .we_out(we), .addr_out(waddr), .data_out(wdata));

    pcr_hub_port_cfg u_pcr_hub_port_cfg (
        .CLK_IN(clk), .RST_N_IN(rst_n), .CFG_WE_IN(we), .CFG_ADDR_IN(waddr),
        .CFG_WDATA_IN(wdata), .CFG_RADDR_IN(raddr), .CFG_RDATA_OUT(rdata),
        .STRAP_MODE_IN(strap_q), .FIXED_DEVICE_STRAPS_IN(straps_q),
        .SELF_POWERED_IN(sp_q), .COMPOUND_CFG_IN(comp_q), .LED_GREEN_IN(grn),
        .LED_AMBER_IN(amb), .SPEED_HS_IN(hs), .SPEED_FS_IN(fs),
        .PORT_INDICATOR_A_N_OUT(a_n), .PORT_INDICATOR_B_N_OUT(b_n),
        .PORT_ACTIVE_OUT(active), .PORT_COUNT_OUT(count), .PORT_NUMBERS_OUT(nums),
        .FIXED_REPORT_OUT(report), .COMPOUND_OUT(compound), .LED_SUPPORT_OUT(led_sup),
        .STRING_EN_OUT(str_en), .REMAP_MODE_OUT(remap));

    task automatic wrap_up();
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string name, input logic [20:0] exp, input logic [20:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int gap);
        u_pcr_loader.write_byte(a, d, gap);
        if (a == 8'h08) m_cfg3 = d & 8'h0F;
        if (a == 8'h09) m_fixed = d & 8'hFE;
        if (a == 8'h0A) m_spoff = d & 8'hFE;
    endtask : wr

    // Read offset is sampled each edge; data is due exactly one edge later
    task automatic check_regs(input logic [7:0] extra);
        logic [7:0] ofs[4];
        int exp[4];
        ofs = '{8'h08, 8'h09, 8'h0A, extra};
        exp = '{m_cfg3, m_fixed, m_spoff, 0};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            raddr <= ofs[i];
            @(posedge clk);
            #1 chk("CFG_RDATA_OUT", 21'(exp[i]), 21'(rdata));
        end
    endtask : check_regs

    // Pins pass two sync flops and outputs one more register
    task automatic check_all();
        int act, fx, cnt, rep, spd;
        logic [20:0] en;
        logic [7:1] ea, eb;
        repeat (6) @(posedge clk);
        #1;
        fx = strap_q ? smap[straps_q] : m_fixed;
        act = (sp_q && m_cfg3[3] == 0) ? (~m_spoff & 8'hFE) : 8'hFE;
        spd = (m_cfg3[2:1] == 1);
        cnt = 0;
        rep = 0;
        en = '0;
        for (int p = 1; p <= 7; p++) begin
            ea[p] = !(act[p] && (spd ? hs[p] : grn[p]));
            eb[p] = !(act[p] && (spd ? fs[p] : amb[p]));
            if (act[p]) begin
                cnt++;
                en[3*p-1 -: 3] = 3'(cnt);
                if (fx[p]) rep |= 1 << cnt;
            end
        end
        chk("PORT_ACTIVE_OUT", 21'(act >> 1), 21'(active));
        chk("PORT_COUNT_OUT", 21'(cnt), 21'(count));
        chk("PORT_NUMBERS_OUT", en, nums);
        chk("FIXED_REPORT_OUT", 21'(rep), 21'(report));
        chk("COMPOUND_OUT", strap_q ? 21'(fx != 0) : 21'(comp_q), 21'(compound));
        chk("LED_SUPPORT_OUT", 21'(!spd), 21'(led_sup));
        chk("STRING_EN_OUT", 21'(m_cfg3[0]), 21'(str_en));
        chk("REMAP_MODE_OUT", 21'(m_cfg3[3]), 21'(remap));
        chk("PORT_INDICATOR_A_N_OUT", 21'(ea), 21'(a_n));
        chk("PORT_INDICATOR_B_N_OUT", 21'(eb), 21'(b_n));
    endtask : check_all

    task automatic rand_pins();
        @(posedge clk);
        sp_q     <= $random(seed);
        raddr    <= 8'h09 + 8'($random(seed) & 1);
        comp_q   <= $random(seed);
        straps_q <= $random(seed);
        grn      <= $random(seed);
        amb      <= $random(seed);
        hs       <= $random(seed);
        fs       <= $random(seed);
    endtask : rand_pins

    initial begin
        #(20000 * 5);
        num_errors++;
        wrap_up();
    end

    initial begin
        @(posedge clk);
        #1 chk("PORT_INDICATOR_A_N_OUT", 21'h7F, 21'(a_n));
        chk("PORT_ACTIVE_OUT", 21'h0, 21'(active));
        @(posedge clk);
        rst_n <= 1'b1;
        check_regs(8'h0B);
        check_all();
        // Every mode code with random reserved high nibble
        for (int v = 0; v < 16; v++) begin
            rand_pins();
            wr(8'h08, 8'(v | ($random(seed) & 8'hF0)), v % 2);
            check_all();
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            strap_q  <= 1'b1;
            straps_q <= 2'(s);
            check_all();
        end
        for (int i = 0; i < 40; i++) begin
            rand_pins();
            strap_q <= (i % 5 == 0);
            wr(8'h09, 8'($random(seed)), 0);
            wr(8'h0A, 8'($random(seed)), 0);
            wr(8'h08, 8'($random(seed)), i % 3);
            wr(8'h0B + 8'(($random(seed) & 3) * 64), 8'hFF, 0);
            check_all();
            if (i % 8 == 0) check_regs(8'(8'h0B + i));
        end
        @(posedge clk);
        rst_n <= 1'b0;
        m_cfg3 = 0;
        m_fixed = 0;
        m_spoff = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        check_regs(8'hFF);
        check_all();
        wrap_up();
    end
endmodule : pcr_hub_port_cfg_test
